// ===== capture_compare_unit.sv
// capture/compare unit with timer one and apb register file
//
// How it works
// - each capture copies the full timer count into both value bytes.
// - capture on falling, rising, every 4th or every 16th rise.
// - a capture sets the sticky event flag; only software clears it.
// - a new capture overwrites the old value without overrun report.
// - pin driven as output in capture mode: port writes can capture.
// - prescaler counter cleared when unit off or not capturing.
// - capture-to-capture switch keeps prescaler; software writes zero first.
// - compare mode checks value against timer count on every update.
// - compare match sets, clears or keeps pin and sets event flag.
// - code 1010 match sets only the flag, pin untouched.
// - code 1011 match sets flag, clears timer, pulses converter start.
// - trigger clear of timer never sets timer overflow flag.
// - software timer write in same cycle beats trigger clear.
// - control zero turns unit off, compare latch low, port latch kept.
// - control bits 5-4 stored but unused in every mode, pwm included.
// - value bytes and control are software readable and writable.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`include "cc_consts.svh"

module capture_compare_unit (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // capture/compare pin
   input  wire logic        cc_pin_in,
   output logic             cc_pin_out,
   output logic             cc_pin_oe_n,
   // converter trigger
   output logic             adc_start
);
   import cc_pkg::*;

   // ****************************************
   // apb access
   // ****************************************
   logic [9:0]  idx;
   logic        done;
   logic        wr;
   logic        mapped;
   logic        pready_reg;
   logic        pready_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pslverr_reg;
   logic        pslverr_next;

   // registers
   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_next;
   logic [15:0] value_reg;
   logic [15:0] value_next;
   logic        event_flag_reg;
   logic        event_flag_next;
   logic        ovf_flag_reg;
   logic        ovf_flag_next;
   logic        event_en_reg;
   logic        event_en_next;
   logic        ovf_en_reg;
   logic        ovf_en_next;
   logic [7:0]  dir_reg;
   logic [7:0]  dir_next;
   logic [7:0]  latch_reg;
   logic [7:0]  latch_next;
   logic        run_reg;
   logic        run_next;

   // compare and pin
   logic        eq_prev_reg;
   logic        cmp_latch_reg;
   logic        cmp_latch_next;
   logic        pin_out_reg;
   logic        pin_out_next;
   logic        oe_n_reg;
   logic        oe_n_next;
   logic        adc_reg;
   logic        adc_next;

   // internal
   logic [15:0] count;
   logic        overflow;
   logic        capture_evt;
   logic        equal;
   logic        match_evt;
   logic        special_hit;
   logic        sample;
   mode_t       mode;

   function automatic logic is_mapped(input logic [9:0] i);
      return i == `CC_LATCH_IDX    || i == `CC_FLAGS_IDX    ||
             i == `CC_TMR_LO_IDX   || i == `CC_TMR_HI_IDX   ||
             i == `CC_TMR_CTRL_IDX || i == `CC_VALUE_LO_IDX ||
             i == `CC_VALUE_HI_IDX || i == `CC_CTRL_IDX     ||
             i == `CC_DIR_IDX      || i == `CC_ENABLES_IDX;
   endfunction

   function automatic logic wr_to(input logic w, input logic [9:0] i,
                                  input logic [9:0] target);
      return w && (i == target);
   endfunction

   assign idx    = paddr[11:2];
   assign mapped = is_mapped(idx);
   assign done   = psel && penable && pready_reg;
   assign wr     = done && pwrite && mapped;
   assign mode   = ctrl_reg[3:0];

   always_comb begin
      pready_next  = psel && penable && !pready_reg;
      pslverr_next = pready_next && !mapped;
      prdata_next  = 32'h0000_0000;
      if (pready_next && !pwrite) begin
         unique case (idx)
            `CC_LATCH_IDX:    prdata_next[7:0] = latch_reg;
            `CC_FLAGS_IDX: begin
               prdata_next[`CC_EVENT_BIT]   = event_flag_reg;
               prdata_next[`CC_TMR_OVF_BIT] = ovf_flag_reg;
            end
            `CC_ENABLES_IDX: begin
               prdata_next[`CC_EVENT_BIT]   = event_en_reg;
               prdata_next[`CC_TMR_OVF_BIT] = ovf_en_reg;
            end
            `CC_TMR_LO_IDX:   prdata_next[7:0] = count[7:0];
            `CC_TMR_HI_IDX:   prdata_next[7:0] = count[15:8];
            `CC_TMR_CTRL_IDX: prdata_next[`CC_TMR_RUN_BIT] = run_reg;
            `CC_VALUE_LO_IDX: prdata_next[7:0] = value_reg[7:0];
            `CC_VALUE_HI_IDX: prdata_next[7:0] = value_reg[15:8];
            `CC_CTRL_IDX:     prdata_next[7:0] = ctrl_reg;
            `CC_DIR_IDX:      prdata_next[7:0] = dir_reg;
            default:          prdata_next      = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ****************************************
   // timer one and capture front end
   // ****************************************
   cc_timer_one u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (run_reg),
      .clear    (special_hit),
      .wr_lo    (wr_to(wr, idx, `CC_TMR_LO_IDX)),
      .wr_hi    (wr_to(wr, idx, `CC_TMR_HI_IDX)),
      .wdata    (pwdata[7:0]),
      .count    (count),
      .overflow (overflow)
   );

   // output pin sees its own driven level
   assign sample = dir_reg[`CC_PIN_BIT] ? cc_pin_in : pin_out_reg;

   cc_capture_edge u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .mode    (mode),
      .sample  (sample),
      .capture (capture_evt)
   );

   // ****************************************
   // registers
   // ****************************************
   always_comb begin
      ctrl_next  = wr_to(wr, idx, `CC_CTRL_IDX) ?
                   {2'b00, pwdata[5:0]} : ctrl_reg;
      dir_next   = wr_to(wr, idx, `CC_DIR_IDX) ?
                   {2'b00, pwdata[5:0]} : dir_reg;
      latch_next = wr_to(wr, idx, `CC_LATCH_IDX) ? pwdata[7:0] : latch_reg;
      run_next   = wr_to(wr, idx, `CC_TMR_CTRL_IDX) ?
                   pwdata[`CC_TMR_RUN_BIT] : run_reg;
      value_next = value_reg;
      if (wr_to(wr, idx, `CC_VALUE_LO_IDX)) begin
         value_next[7:0] = pwdata[7:0];
      end
      if (wr_to(wr, idx, `CC_VALUE_HI_IDX)) begin
         value_next[15:8] = pwdata[7:0];
      end
      if (capture_evt) begin
         value_next = count;
      end
      event_en_next   = event_en_reg;
      ovf_en_next     = ovf_en_reg;
      event_flag_next = event_flag_reg;
      ovf_flag_next   = ovf_flag_reg;
      if (wr_to(wr, idx, `CC_ENABLES_IDX)) begin
         event_en_next = pwdata[`CC_EVENT_BIT];
         ovf_en_next   = pwdata[`CC_TMR_OVF_BIT];
      end
      if (wr_to(wr, idx, `CC_FLAGS_IDX)) begin
         event_flag_next = pwdata[`CC_EVENT_BIT];
         ovf_flag_next   = pwdata[`CC_TMR_OVF_BIT];
      end
      // hardware set wins over software clear
      if (capture_evt || match_evt) begin
         event_flag_next = 1'b1;
      end
      if (overflow) begin
         ovf_flag_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg       <= `CC_CTRL_RESET;
         dir_reg        <= `CC_DIR_RESET;
         latch_reg      <= `CC_BYTE_RESET;
         run_reg        <= 1'b0;
         value_reg      <= `CC_WORD_RESET;
         event_en_reg   <= 1'b0;
         ovf_en_reg     <= 1'b0;
         event_flag_reg <= 1'b0;
         ovf_flag_reg   <= 1'b0;
      end else begin
         ctrl_reg       <= ctrl_next;
         dir_reg        <= dir_next;
         latch_reg      <= latch_next;
         run_reg        <= run_next;
         value_reg      <= value_next;
         event_en_reg   <= event_en_next;
         ovf_en_reg     <= ovf_en_next;
         event_flag_reg <= event_flag_next;
         ovf_flag_reg   <= ovf_flag_next;
      end
   end

   // ****************************************
   // compare and pin drive
   // ****************************************
   always_comb begin
      equal       = (count == value_reg);
      match_evt   = (kind_of(mode) == KIND_COMPARE) && equal && !eq_prev_reg;
      special_hit = match_evt && (mode == `CC_MODE_CMP_SPEC);
      adc_next    = special_hit;
      cmp_latch_next = cmp_latch_reg;
      if (mode == `CC_MODE_OFF) begin
         cmp_latch_next = 1'b0;
      end else if (match_evt && mode == `CC_MODE_CMP_HIGH) begin
         cmp_latch_next = 1'b1;
      end else if (match_evt && mode == `CC_MODE_CMP_LOW) begin
         cmp_latch_next = 1'b0;
      end
      // soft and special codes leave the latch
      pin_out_next = (kind_of(ctrl_next[3:0]) == KIND_COMPARE) ?
                     cmp_latch_next : latch_next[`CC_PIN_BIT];
      oe_n_next    = dir_next[`CC_PIN_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eq_prev_reg   <= 1'b0;
         cmp_latch_reg <= 1'b0;
         pin_out_reg   <= 1'b0;
         oe_n_reg      <= 1'b1;
         adc_reg       <= 1'b0;
      end else begin
         eq_prev_reg   <= equal;
         cmp_latch_reg <= cmp_latch_next;
         pin_out_reg   <= pin_out_next;
         oe_n_reg      <= oe_n_next;
         adc_reg       <= adc_next;
      end
   end

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign cc_pin_out  = pin_out_reg;
   assign cc_pin_oe_n = oe_n_reg;
   assign adc_start   = adc_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_capture_copy: assert property (
      capture_evt |=> value_reg == $past(count))
      else $error("capture did not copy timer count");

   a_flag_sticky: assert property (
      event_flag_reg && !wr_to(wr, idx, `CC_FLAGS_IDX) |=> event_flag_reg)
      else $error("event flag dropped without software clear");

   a_event_sets_flag: assert property (
      capture_evt || match_evt |=> event_flag_reg)
      else $error("event did not set flag");

   a_high_on_match: assert property (
      match_evt && mode == `CC_MODE_CMP_HIGH |=> cmp_latch_reg && pin_out_reg)
      else $error("compare high did not drive pin");

   a_soft_keeps_pin: assert property (
      match_evt && mode == `CC_MODE_CMP_SOFT
      |=> cmp_latch_reg == $past(cmp_latch_reg))
      else $error("soft compare touched the latch");

   a_special_clear: assert property (
      special_hit && !wr_to(wr, idx, `CC_TMR_LO_IDX)
      && !wr_to(wr, idx, `CC_TMR_HI_IDX)
      |=> count == 16'h0000 && adc_start ##1 !adc_start)
      else $error("special trigger did not clear timer");

   a_no_ovf_clear: assert property (
      special_hit && !wr_to(wr, idx, `CC_FLAGS_IDX)
      |=> ovf_flag_reg == $past(ovf_flag_reg))
      else $error("trigger clear changed overflow flag");

   a_write_wins: assert property (
      special_hit && wr_to(wr, idx, `CC_TMR_LO_IDX)
      |=> count[7:0] == $past(pwdata[7:0]))
      else $error("timer write lost to trigger clear");

   a_off_latch: assert property (
      mode == `CC_MODE_OFF |=> !cmp_latch_reg)
      else $error("unit off but compare latch high");

   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("ready held for two cycles");

   c_capture: cover property (capture_evt ##1 event_flag_reg);
   c_special: cover property (special_hit ##1 adc_start);
   c_cmp_low: cover property (match_evt && mode == `CC_MODE_CMP_LOW);
   c_err:     cover property (pslverr);

endmodule // capture_compare_unit

// ===== capture_compare_unit_test.sv
// self-checking testbench for the capture/compare unit
`timescale 1ns/10ps
`include "cc_consts.svh"

module capture_compare_unit_test;
   logic        pclk, presetn, psel, penable, pwrite, ext_level;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, cc_pin_in, cc_pin_out;
   logic        cc_pin_oe_n, adc_start, err;
   logic [3:0]  modes [5] = '{4'h8, 4'hB, 4'h9, 4'h8, 4'hA};
   logic        pins [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   int          failures, n_checks, adc_pulses, cnt;

   capture_compare_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
      .cc_pin_oe_n(cc_pin_oe_n), .adc_start(adc_start));

   cc_pin_source far_side (.pclk(pclk), .level(ext_level),
      .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n),
      .cc_pin_in(cc_pin_in));

   // ****************************************
   // clock and monitors
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (adc_start === 1'b1) adc_pulses++;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [7:0] wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         failures++;
         final_report();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp);
   endtask

   task automatic set_timer(input logic [7:0] hi, input logic [7:0] lo);
      wr(`CC_TMR_HI_IDX, hi);
      wr(`CC_TMR_LO_IDX, lo);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         ext_level <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_level <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask

   task automatic wait_flag;
      int k;
      for (k = 0; k < 40; k++) begin
         apb(1'b0, `CC_FLAGS_IDX, 8'h00);
         if (rd[`CC_EVENT_BIT] === 1'b1) break;
      end
      if (k == 40) begin
         failures++;
         final_report();
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, ext_level} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`CC_CTRL_IDX, 32'h00);
      rd_chk(`CC_FLAGS_IDX, 32'h00);
      rd_chk(`CC_ENABLES_IDX, 32'h00);
      rd_chk(`CC_DIR_IDX, 32'h3F);
      apb(1'b0, 10'h3FF, 8'h00);
      chk({31'h0, err}, 32'h1);
      wr(`CC_CTRL_IDX, 8'hFF);
      rd_chk(`CC_CTRL_IDX, 32'h3F);
      wr(`CC_CTRL_IDX, 8'h00);
      wr(`CC_VALUE_LO_IDX, 8'hA5);
      wr(`CC_VALUE_HI_IDX, 8'h5A);
      rd_chk(`CC_VALUE_LO_IDX, 32'hA5);
      rd_chk(`CC_VALUE_HI_IDX, 32'h5A);
      // capture on a rising edge, then overwrite on a falling edge
      set_timer(8'h12, 8'h34);
      wr(`CC_CTRL_IDX, 8'h35);
      pulses(1);
      rd_chk(`CC_VALUE_LO_IDX, 32'h34);
      rd_chk(`CC_VALUE_HI_IDX, 32'h12);
      rd_chk(`CC_FLAGS_IDX, 32'h04);
      wr(`CC_CTRL_IDX, 8'h00);
      set_timer(8'h56, 8'h78);
      wr(`CC_CTRL_IDX, 8'h04);
      wr(`CC_FLAGS_IDX, 8'h00);
      pulses(1);
      rd_chk(`CC_VALUE_LO_IDX, 32'h78);
      rd_chk(`CC_VALUE_HI_IDX, 32'h56);
      rd_chk(`CC_FLAGS_IDX, 32'h04);
      wr(`CC_FLAGS_IDX, 8'h00);
      // prescaled captures, counter cleared while off
      for (int i = 0; i < 2; i++) begin
         cnt = i ? 16 : 4;
         wr(`CC_CTRL_IDX, 8'h00);
         set_timer(8'(i), 8'(cnt));
         wr(`CC_CTRL_IDX, i ? 8'h07 : 8'h06);
         pulses(cnt - 1);
         wr(`CC_CTRL_IDX, 8'h00);
         wr(`CC_FLAGS_IDX, 8'h00);
         wr(`CC_CTRL_IDX, i ? 8'h07 : 8'h06);
         pulses(cnt - 1);
         rd_chk(`CC_FLAGS_IDX, 32'h00);
         pulses(1);
         rd_chk(`CC_FLAGS_IDX, 32'h04);
         rd_chk(`CC_VALUE_LO_IDX, 32'(cnt));
         wr(`CC_FLAGS_IDX, 8'h00);
      end
      // pin as output: a port latch write captures
      wr(`CC_CTRL_IDX, 8'h00);
      wr(`CC_DIR_IDX, 8'h3B);
      wr(`CC_CTRL_IDX, 8'h05);
      wr(`CC_LATCH_IDX, 8'h04);
      repeat (3) @(posedge pclk);
      rd_chk(`CC_FLAGS_IDX, 32'h04);
      wr(`CC_LATCH_IDX, 8'h00);
      wr(`CC_CTRL_IDX, 8'h00);
      // compare modes against a stopped then running timer
      wr(`CC_VALUE_HI_IDX, 8'h00);
      wr(`CC_VALUE_LO_IDX, 8'h20);
      for (int i = 0; i < 5; i++) begin
         wr(`CC_TMR_CTRL_IDX, 8'h00);
         set_timer(8'h00, 8'h00);
         wr(`CC_FLAGS_IDX, 8'h00);
         adc_pulses = 0;
         wr(`CC_CTRL_IDX, {4'h0, modes[i]});
         wr(`CC_TMR_CTRL_IDX, 8'h01);
         wait_flag();
         chk({31'h0, cc_pin_out}, {31'h0, pins[i]});
         chk({31'h0, cc_pin_oe_n}, 32'h0);
         if (modes[i] == 4'hB) begin
            chk({31'h0, adc_pulses != 0}, 32'h1);
            rd_chk(`CC_FLAGS_IDX, 32'h04);
            apb(1'b0, `CC_TMR_LO_IDX, 8'h00);
            chk({31'h0, rd <= 32'h20}, 32'h1);
         end else begin
            chk(32'(adc_pulses), 32'h0);
         end
      end
      // control zero: compare latch low, port latch kept
      wr(`CC_LATCH_IDX, 8'h04);
      wr(`CC_CTRL_IDX, 8'h00);
      wr(`CC_CTRL_IDX, 8'h0A);
      repeat (2) @(posedge pclk);
      chk({31'h0, cc_pin_out}, 32'h0);
      rd_chk(`CC_LATCH_IDX, 32'h04);
      // timer write lands in the very cycle of the trigger clear
      wr(`CC_TMR_CTRL_IDX, 8'h00);
      set_timer(8'h00, 8'h00);
      wr(`CC_VALUE_LO_IDX, 8'h03);
      wr(`CC_CTRL_IDX, 8'h0B);
      wr(`CC_TMR_CTRL_IDX, 8'h01);
      wr(`CC_TMR_LO_IDX, 8'h55);
      apb(1'b0, `CC_TMR_LO_IDX, 8'h00);
      chk({31'h0, rd[7:0] >= 8'h55}, 32'h1);
      final_report();
   end

   initial begin
      #1000000;
      failures++;
      final_report();
   end
endmodule // capture_compare_unit_test

// ===== cc_capture_edge.sv
// capture edge selection and edge prescaler
`timescale 1ns/10ps
`include "cc_consts.svh"

module cc_capture_edge
   import cc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // selection
   input  cc_pkg::mode_t    mode,
   input  wire logic        sample,
   // event
   output logic             capture
);

   logic       prev_reg;
   logic       prev_next;
   logic [3:0] count_reg;
   logic [3:0] count_next;
   logic       rise;
   logic       fall;

   always_comb begin
      rise       = sample && !prev_reg;
      fall       = !sample && prev_reg;
      prev_next  = sample;
      count_next = count_reg;
      capture    = 1'b0;
      if (kind_of(mode) != KIND_CAPTURE) begin
         count_next = 4'h0;
      end else begin
         // counter kept across capture modes
         unique case (mode[1:0])
            2'b00: capture = fall;
            2'b01: capture = rise;
            2'b10: begin
               if (rise) begin
                  capture    = (count_reg == `CC_PRE4_LAST);
                  count_next = capture ? 4'h0 : count_reg + 4'h1;
               end
            end
            2'b11: begin
               if (rise) begin
                  capture    = (count_reg == `CC_PRE16_LAST);
                  count_next = count_reg + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg  <= 1'b0;
         count_reg <= 4'h0;
      end else begin
         prev_reg  <= prev_next;
         count_reg <= count_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_prescale_clear: assert property (
      kind_of(mode) != KIND_CAPTURE |=> count_reg == 4'h0)
      else $error("prescaler not cleared outside capture");

   a_fourth_rise: assert property (
      mode == `CC_MODE_CAP_R4 && rise && count_reg == `CC_PRE4_LAST
      |-> capture ##1 count_reg == 4'h0)
      else $error("fourth rising edge not captured");

   a_fall_only: assert property (
      mode == `CC_MODE_CAP_FALL |-> capture == fall)
      else $error("falling edge mode misbehaves");

endmodule // cc_capture_edge

// ===== cc_consts.svh
// register indices, field positions, codes and reset values
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define CC_LATCH_IDX      10'h007
`define CC_FLAGS_IDX      10'h00C
`define CC_TMR_LO_IDX     10'h00E
`define CC_TMR_HI_IDX     10'h00F
`define CC_TMR_CTRL_IDX   10'h010
`define CC_VALUE_LO_IDX   10'h015
`define CC_VALUE_HI_IDX   10'h016
`define CC_CTRL_IDX       10'h017
`define CC_DIR_IDX        10'h087
`define CC_ENABLES_IDX    10'h08C

// ****************************************
// field positions
// ****************************************
`define CC_EVENT_BIT      2
`define CC_TMR_OVF_BIT    0
`define CC_PIN_BIT        2
`define CC_TMR_RUN_BIT    0

// ****************************************
// mode select codes
// ****************************************
`define CC_MODE_OFF       4'h0
`define CC_MODE_CAP_FALL  4'h4
`define CC_MODE_CAP_RISE  4'h5
`define CC_MODE_CAP_R4    4'h6
`define CC_MODE_CAP_R16   4'h7
`define CC_MODE_CMP_HIGH  4'h8
`define CC_MODE_CMP_LOW   4'h9
`define CC_MODE_CMP_SOFT  4'hA
`define CC_MODE_CMP_SPEC  4'hB

// ****************************************
// prescaler terminal counts and reset values
// ****************************************
`define CC_PRE4_LAST      4'h3
`define CC_PRE16_LAST     4'hF
`define CC_CTRL_RESET     8'h00
`define CC_DIR_RESET      8'h3F
`define CC_BYTE_RESET     8'h00
`define CC_WORD_RESET     16'h0000

`endif

// ===== cc_pin_source.sv
// model of the outside driver on the capture/compare pin
`timescale 1ns/10ps

module cc_pin_source (
   // clock
   input  wire logic pclk,
   // level requested by the bench
   input  wire logic level,
   // unit side of the pin
   input  wire logic cc_pin_out,
   input  wire logic cc_pin_oe_n,
   output logic      cc_pin_in
);
   logic ext_q;

   // outside level changes just after an edge
   always_ff @(posedge pclk) begin
      ext_q <= level;
   end

   // wire level: unit wins while it drives the pin
   assign cc_pin_in = cc_pin_oe_n ? ext_q : cc_pin_out;
endmodule // cc_pin_source

// ===== cc_pkg.sv
// shared types for the capture/compare unit
package cc_pkg;

   typedef logic [3:0] mode_t;

   typedef enum logic [1:0] {
      KIND_OFF,
      KIND_CAPTURE,
      KIND_COMPARE,
      KIND_PWM
   } mode_kind_e;

   // reserved codes 0001..0011 behave as off but keep the compare latch
   function automatic mode_kind_e kind_of(input mode_t m);
      if (m[3:2] == 2'b11) begin
         return KIND_PWM;
      end else if (m[3]) begin
         return KIND_COMPARE;
      end else if (m[2]) begin
         return KIND_CAPTURE;
      end
      return KIND_OFF;
   endfunction

endpackage

// ===== cc_timer_one.sv
// sixteen-bit timer one count with write and trigger clear
`timescale 1ns/10ps
`include "cc_consts.svh"

module cc_timer_one (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // control
   input  wire logic        run,
   input  wire logic        clear,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [7:0]  wdata,
   // state
   output logic      [15:0] count,
   output logic             overflow
);

   logic [15:0] count_reg;
   logic [15:0] count_next;

   always_comb begin
      count_next = count_reg;
      overflow   = 1'b0;
      if (wr_lo || wr_hi) begin
         // software write beats the trigger clear
         if (wr_lo) begin
            count_next[7:0] = wdata;
         end
         if (wr_hi) begin
            count_next[15:8] = wdata;
         end
      end else if (clear) begin
         // trigger clear raises no overflow
         count_next = `CC_WORD_RESET;
      end else if (run) begin
         count_next = count_reg + 16'h0001;
         overflow   = (count_reg == 16'hFFFF);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= `CC_WORD_RESET;
      end else begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

endmodule // cc_timer_one
